// File: hw/emt_regs.vh
// register map, field positions, reset values and timing counts of the external memory timing block
`ifndef EMT_REGS_VH
`define EMT_REGS_VH

// register byte offsets on the avalon slave
`define EMT_OFF_TIMING 5'h00
`define EMT_OFF_CONFIG 5'h04
`define EMT_OFF_PAGE 5'h08
`define EMT_OFF_BPTR 5'h0c
`define EMT_OFF_DATA_POINTER 5'h10
`define EMT_OFF_ACCESS 5'h14
`define EMT_OFF_STATUS 5'h18

// reset values
`define EMT_RST_TIMING 8'hff
`define EMT_RST_CONFIG 5'h03
`define EMT_RST_PAGE 8'h00

// timing control fields
`define EMT_TC_SETUP_HI 7
`define EMT_TC_SETUP_LO 6
`define EMT_TC_STROBE_HI 5
`define EMT_TC_STROBE_LO 2
`define EMT_TC_HOLD_HI 1
`define EMT_TC_HOLD_LO 0

// config fields
`define EMT_CF_MUX_SEL 4
`define EMT_CF_MODE_HI 3
`define EMT_CF_MODE_LO 2
`define EMT_CF_LATCH_HI 1
`define EMT_CF_LATCH_LO 0

// operating modes
`define EMT_MODE_INTERNAL 2'h0
`define EMT_MODE_SPLIT_NOBANK 2'h1
`define EMT_MODE_SPLIT_BANK 2'h2
`define EMT_MODE_EXT_ONLY 2'h3

// access register fields
`define EMT_AC_WIDE 8
`define EMT_AC_WRITE 9

// status register fields
`define EMT_ST_OFFCHIP 8

// first address above the on-chip space
`define EMT_ONCHIP_LIMIT 16'h1000

// fixed cycles of an off-chip access: one lead cycle plus three tail cycles
`define EMT_FIXED_CYCLES 4
`define EMT_LEAD_CYCLES 1
`define EMT_TAIL_CYCLES (`EMT_FIXED_CYCLES - `EMT_LEAD_CYCLES)

`endif

// File: hw/emt_on_chip_ext_space_ram.v
// on-chip external-space ram with registered read data
`timescale 1ns/1ns
module emt_on_chip_ext_space_ram #(
  parameter AW = 12,
  parameter DW = 8
) (
  input wire mclk_i,
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  // read-before-write; contents are undefined after power-up, as on a real ram
  always @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end
endmodule

// File: hw/emt_ctrl.v
// external data memory interface: address routing, access sequencer and avalon register slave
`timescale 1ns/1ns
`include "emt_regs.vh"

module emt_ctrl (
  input wire mclk_i,
  input wire nrst_i,
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  output reg [7:0] addr_hi_o,
  output reg addr_hi_oe_n_o,
  output reg [7:0] addr_lo_o,
  output reg addr_lo_oe_n_o,
  input wire [7:0] ad_i,
  output reg [7:0] ad_o,
  output reg ad_oe_n_o,
  output reg ale_o,
  output reg rd_n_o,
  output reg wr_n_o
);
  // one-hot sequencer states
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_LEAD = 9'h002;
  localparam [8:0] ST_ALEH = 9'h004;
  localparam [8:0] ST_ALEL = 9'h008;
  localparam [8:0] ST_SETUP = 9'h010;
  localparam [8:0] ST_STROBE = 9'h020;
  localparam [8:0] ST_HOLD = 9'h040;
  localparam [8:0] ST_TAIL = 9'h080;
  localparam [8:0] ST_ONCHIP = 9'h100;
  localparam integer TAIL_N = `EMT_TAIL_CYCLES - 1;
  localparam [3:0] TAIL_LAST = TAIL_N[3:0];
  reg [7:0] timing_q;
  reg [4:0] config_q;
  reg [7:0] page_q;
  reg [7:0] bptr_q;
  reg [15:0] data_pointer_q;
  reg [8:0] state_q;
  reg [8:0] state_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg started_q;
  reg wide_q;
  reg wr_q;
  reg [7:0] wdata_q;
  reg offchip_q;
  reg [7:0] rdata_q;
  reg [2:0] strobe_end_q;
  reg [7:0] din_s1_q;
  reg [7:0] din_s2_q;
  reg [7:0] din_s3_q;
  wire [7:0] ram_rdata;

  // field views of the timing and config registers
  wire [1:0] setup_w = timing_q[`EMT_TC_SETUP_HI:`EMT_TC_SETUP_LO];
  wire [3:0] strobe_w = timing_q[`EMT_TC_STROBE_HI:`EMT_TC_STROBE_LO];
  wire [1:0] hold_w = timing_q[`EMT_TC_HOLD_HI:`EMT_TC_HOLD_LO];
  wire [1:0] mode_w = config_q[`EMT_CF_MODE_HI:`EMT_CF_MODE_LO];
  wire [1:0] latch_w = config_q[`EMT_CF_LATCH_HI:`EMT_CF_LATCH_LO];
  // bit clear selects shared address/data pins, so 0xx codes are multiplexed
  wire mux_w = ~config_q[`EMT_CF_MUX_SEL];

  // bus decode; the access register starts a transfer and stalls the bus until it ends
  wire req_w = avs_read_i | avs_write_i;
  wire acc_req_w = avs_write_i && (avs_address_i == `EMT_OFF_ACCESS);
  wire start_w = acc_req_w && avs_waitrequest_o && !started_q && (state_q == ST_IDLE);
  wire new_wide_w = avs_writedata_i[`EMT_AC_WIDE];
  wire new_wr_w = avs_writedata_i[`EMT_AC_WRITE];
  wire reg_wr_w = avs_write_i && !avs_waitrequest_o;

  // effective address: page + pointer for byte accesses, data pointer for word accesses
  wire [15:0] byte_addr_w = {page_q, bptr_q};
  wire [15:0] eff_addr_w = new_wide_w ? data_pointer_q : byte_addr_w;
  wire [15:0] acc_addr_w = wide_q ? data_pointer_q : byte_addr_w;

  // routing decision taken once at the start of an access
  function route_off;
    input [1:0] mode;
    input [15:0] addr;
    begin
      case (mode)
        `EMT_MODE_EXT_ONLY: route_off = 1'b1;
        `EMT_MODE_INTERNAL: route_off = 1'b0;
        default: route_off = (addr >= `EMT_ONCHIP_LIMIT);
      endcase
    end
  endfunction

  // upper lines are driven for word accesses, and for byte accesses only with bank select
  function hi_driven;
    input wide;
    input [1:0] mode;
    begin
      hi_driven = wide || (mode == `EMT_MODE_SPLIT_BANK);
    end
  endfunction

  // entry into the setup phase, skipping it when the setup field is zero
  function [12:0] enter_setup;
    input [1:0] setup;
    input [3:0] strobe;
    begin
      if (setup != 2'h0) begin
        enter_setup = {ST_SETUP, {2'h0, setup} - 4'h1};
      end else begin
        enter_setup = {ST_STROBE, strobe};
      end
    end
  endfunction
  wire offchip_now_w = route_off(mode_w, eff_addr_w);
  wire done_w = ((state_q == ST_TAIL) && (cnt_q == 4'h0)) || (state_q == ST_ONCHIP);
  // next state: lead, latch high, latch low, setup, strobe, hold, tail; counters run down
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q - 4'h1; // every phase ends at zero, so wrapping outside a phase is harmless
    case (state_q)
      ST_IDLE: begin
        cnt_d = 4'h0;
        if (start_w) begin
          state_d = offchip_now_w ? ST_LEAD : ST_ONCHIP;
        end
      end
      ST_LEAD: begin
        if (mux_w) begin
          state_d = ST_ALEH;
          cnt_d = {2'h0, latch_w};
        end else begin
          {state_d, cnt_d} = enter_setup(setup_w, strobe_w);
        end
      end
      ST_ALEH: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_ALEL;
          cnt_d = {2'h0, latch_w};
        end
      end
      ST_ALEL: begin
        if (cnt_q == 4'h0) begin
          {state_d, cnt_d} = enter_setup(setup_w, strobe_w);
        end
      end
      ST_SETUP: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_STROBE;
          cnt_d = strobe_w;
        end
      end
      ST_STROBE: begin
        if ((cnt_q == 4'h0) && (hold_w != 2'h0)) begin
          state_d = ST_HOLD;
          cnt_d = {2'h0, hold_w} - 4'h1;
        end else if (cnt_q == 4'h0) begin
          state_d = ST_TAIL;
          cnt_d = TAIL_LAST;
        end
      end
      ST_HOLD: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_TAIL;
          cnt_d = TAIL_LAST;
        end
      end
      ST_TAIL: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_IDLE;
        end
      end
      ST_ONCHIP: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end
  // command fields as seen by the pin logic in the cycle they are taken
  wire wide_d = start_w ? new_wide_w : wide_q;
  wire wr_d = start_w ? new_wr_w : wr_q;
  wire [7:0] wdata_d = start_w ? avs_writedata_i[7:0] : wdata_q;
  wire [15:0] addr_d = start_w ? eff_addr_w : acc_addr_w;
  wire drive_d = |(state_d & (ST_LEAD | ST_ALEH | ST_ALEL | ST_SETUP | ST_STROBE | ST_HOLD));
  wire ad_addr_d = mux_w && |(state_d & (ST_LEAD | ST_ALEH | ST_ALEL));
  wire strobe_d = (state_d == ST_STROBE);
  // sequencer and pins; pins are registered from the next state so they change with it
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      wide_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      offchip_q <= 1'b0;
      addr_hi_o <= 8'h00;
      addr_hi_oe_n_o <= 1'b1;
      addr_lo_o <= 8'h00;
      addr_lo_oe_n_o <= 1'b1;
      ad_o <= 8'h00;
      ad_oe_n_o <= 1'b1;
      ale_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wide_q <= wide_d;
      wr_q <= wr_d;
      wdata_q <= wdata_d;
      if (start_w) begin
        offchip_q <= offchip_now_w;
      end
      addr_hi_o <= addr_d[15:8];
      addr_hi_oe_n_o <= !(drive_d && hi_driven(wide_d, mode_w));
      addr_lo_o <= addr_d[7:0];
      addr_lo_oe_n_o <= !(drive_d && !mux_w);
      // shared pins carry the low address through the lead and both latch phases, then data
      ad_o <= ad_addr_d ? addr_d[7:0] : wdata_d;
      ad_oe_n_o <= !(ad_addr_d || (wr_d && drive_d));
      ale_o <= (state_d == ST_ALEH);
      rd_n_o <= !(strobe_d && !wr_d);
      wr_n_o <= !(strobe_d && wr_d);
    end
  end
  // pin data at the last strobe edge reaches the third stage two edges later and counts
  // only if the second stage agrees, so memory must hold it one cycle past the strobe
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
      din_s3_q <= 8'h00;
      strobe_end_q <= 3'h0;
      rdata_q <= 8'h00;
    end else begin
      din_s1_q <= ad_i;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
      strobe_end_q <= {strobe_end_q[1:0], (state_q == ST_STROBE) && (cnt_q == 4'h0) && !wr_q};
      if (strobe_end_q[2] && (din_s2_q == din_s3_q)) begin
        rdata_q <= din_s3_q;
      end else if ((state_q == ST_ONCHIP) && !wr_q) begin
        rdata_q <= ram_rdata;
      end
    end
  end
  // on-chip ram sees the access in its start cycle; it is never touched in external-only mode
  emt_on_chip_ext_space_ram #(
    .AW(12),
    .DW(8)
  ) u_on_chip_ext_space_ram (
    .mclk_i(mclk_i),
    .we_i(start_w && !offchip_now_w && new_wr_w),
    .addr_i(eff_addr_w[11:0]),
    .wdata_i(avs_writedata_i[7:0]),
    .rdata_o(ram_rdata)
  );
  // register read mux; unmapped offsets read zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `EMT_OFF_TIMING: rd_mux = {24'h0, timing_q};
      `EMT_OFF_CONFIG: rd_mux = {27'h0, config_q};
      `EMT_OFF_PAGE: rd_mux = {24'h0, page_q};
      `EMT_OFF_BPTR: rd_mux = {24'h0, bptr_q};
      `EMT_OFF_DATA_POINTER: rd_mux = {16'h0, data_pointer_q};
      `EMT_OFF_STATUS: rd_mux = {23'h0, offchip_q, rdata_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // avalon handshake: one wait cycle for plain registers, the whole transfer for the access
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      started_q <= 1'b0;
    end else if (!avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b1;
    end else if (req_w) begin
      if (!acc_req_w) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= avs_read_i ? rd_mux : 32'h0000_0000;
      end else if (started_q && done_w) begin
        avs_waitrequest_o <= 1'b0;
        started_q <= 1'b0;
      end else if (start_w) begin
        started_q <= 1'b1;
      end
    end
  end

  // register writes land on the edge where waitrequest is seen low
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      timing_q <= `EMT_RST_TIMING;
      config_q <= `EMT_RST_CONFIG;
      page_q <= `EMT_RST_PAGE;
      bptr_q <= 8'h00;
      data_pointer_q <= 16'h0000;
    end else if (reg_wr_w) begin
      case (avs_address_i)
        `EMT_OFF_TIMING: if (avs_byteenable_i[0]) timing_q <= avs_writedata_i[7:0];
        `EMT_OFF_CONFIG: if (avs_byteenable_i[0]) config_q <= avs_writedata_i[4:0];
        `EMT_OFF_PAGE: if (avs_byteenable_i[0]) page_q <= avs_writedata_i[7:0];
        `EMT_OFF_BPTR: if (avs_byteenable_i[0]) bptr_q <= avs_writedata_i[7:0];
        `EMT_OFF_DATA_POINTER: begin
          if (avs_byteenable_i[0]) data_pointer_q[7:0] <= avs_writedata_i[7:0];
          if (avs_byteenable_i[1]) data_pointer_q[15:8] <= avs_writedata_i[15:8];
        end
        default: ;
      endcase
    end
  end
endmodule

// File: tb/emt_ctrl_properties.sv
// port-level assertions for the external memory timing block
`timescale 1ns/1ns
`include "emt_regs.vh"
module emt_ctrl_chk (
  input wire mclk_i,
  input wire nrst_i,
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire [7:0] addr_hi_o,
  input wire addr_hi_oe_n_o,
  input wire [7:0] addr_lo_o,
  input wire addr_lo_oe_n_o,
  input wire [7:0] ad_i,
  input wire [7:0] ad_o,
  input wire ad_oe_n_o,
  input wire ale_o,
  input wire rd_n_o,
  input wire wr_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // pins and bus must come out of reset parked
  a_reset_idle: assert property ($past(!nrst_i) |-> avs_waitrequest_o && rd_n_o && wr_n_o
    && !ale_o && ad_oe_n_o && addr_hi_oe_n_o && addr_lo_oe_n_o && avs_readdata_o == 32'h0)
    else $error("outputs not idle after reset");
  a_plain_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    && avs_address_i != `EMT_OFF_ACCESS |=> !avs_waitrequest_o)
    else $error("register access not answered next cycle");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  // the three tail cycles follow every strobe
  a_tail_wait: assert property ($rose(rd_n_o) || $rose(wr_n_o) |-> avs_waitrequest_o[*3])
    else $error("access completed inside its tail");
  a_strobe_excl: assert property (rd_n_o || wr_n_o)
    else $error("both strobes low");
  a_mux_addr: assert property (ale_o |-> !ad_oe_n_o && rd_n_o && wr_n_o)
    else $error("shared pins not carrying address while latch open");
  a_wdata_drive: assert property (!wr_n_o |-> !ad_oe_n_o)
    else $error("write strobe without data driven");
  a_read_release: assert property (!rd_n_o |-> ad_oe_n_o)
    else $error("data pins driven during read strobe");
  a_latch_gap: assert property ($fell(ale_o) |-> !ale_o[*1] ##0 rd_n_o && wr_n_o)
    else $error("strobe at latch close");
endmodule
bind emt_ctrl emt_ctrl_chk u_chk (.mclk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .addr_hi_o,
  .addr_hi_oe_n_o, .addr_lo_o, .addr_lo_oe_n_o, .ad_i, .ad_o, .ad_oe_n_o, .ale_o, .rd_n_o,
  .wr_n_o);

// File: tb/emt_sram.sv
// behavioural external parallel sram with its address latch
`timescale 1ns/1ns
module emt_sram (
  input wire mclk_i,
  input wire [7:0] addr_hi_o,
  input wire addr_hi_oe_n_o,
  input wire [7:0] addr_lo_o,
  input wire addr_lo_oe_n_o,
  input wire [7:0] ad_o,
  input wire ale_o,
  input wire rd_n_o,
  input wire wr_n_o,
  output wire [7:0] ad_i,
  output logic [15:0] last_addr,
  output logic last_hi_drv,
  output logic [7:0] last_width,
  output logic [7:0] n_strobe
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_q = 8'h00;
  logic [7:0] rdat_q = 8'h00;
  logic [7:0] w_q = 8'h00;
  logic [1:0] hold_q = 2'h0;
  // undriven upper lines sit at the pulled-up level; muxed low byte comes from the latch
  wire [15:0] a = {addr_hi_oe_n_o ? 8'hff : addr_hi_o, addr_lo_oe_n_o ? lat_q : addr_lo_o};
  // data held only two cycles past the strobe, then the pins wander
  assign ad_i = !rd_n_o ? mem[a] : (hold_q != 2'h0 ? rdat_q : ~rdat_q);
  initial begin
    last_width = 8'h00;
    n_strobe = 8'h00;
  end
  always @(posedge mclk_i) begin
    if (ale_o) lat_q <= ad_o; // latch transparent while open
    if (!rd_n_o || !wr_n_o) begin
      w_q <= w_q + 8'h01;
      last_addr <= a;
      last_hi_drv <= !addr_hi_oe_n_o;
    end else if (w_q != 8'h00) begin
      last_width <= w_q;
      n_strobe <= n_strobe + 8'h01;
      w_q <= 8'h00;
    end
    if (!wr_n_o) mem[a] <= ad_o;
    if (!rd_n_o) begin
      rdat_q <= mem[a];
      hold_q <= 2'h2;
    end else if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
  end
endmodule

// File: tb/tb.sv
// self-checking bench for the external memory timing block
`timescale 1ns/1ns
`include "emt_regs.vh"
module tb;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h0;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, addr_hi_oe_n_o, addr_lo_oe_n_o, ad_oe_n_o, ale_o, rd_n_o, wr_n_o;
  wire [7:0] addr_hi_o, addr_lo_o, ad_i, ad_o, m_width, m_cnt;
  wire [15:0] m_addr;
  wire m_hi;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int lat;
  logic [31:0] rd;
  logic [7:0] cnt0;
  logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  logic [7:0] tms [4] = '{8'hff, 8'h94, 8'h47, 8'h3c};

  always #20 mclk_i = ~mclk_i;

  emt_ctrl dut (.mclk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .addr_hi_o, .addr_hi_oe_n_o,
    .addr_lo_o, .addr_lo_oe_n_o, .ad_i, .ad_o, .ad_oe_n_o, .ale_o, .rd_n_o, .wr_n_o);
  emt_sram mem_model (.mclk_i, .addr_hi_o, .addr_hi_oe_n_o, .addr_lo_o, .addr_lo_oe_n_o, .ad_o,
    .ale_o, .rd_n_o, .wr_n_o, .ad_i, .last_addr(m_addr), .last_hi_drv(m_hi),
    .last_width(m_width), .n_strobe(m_cnt));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // a hung handshake ends the run here
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one avalon transfer; lat counts edges up to the completing one
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= (a == `EMT_OFF_DATA_POINTER || a == `EMT_OFF_ACCESS) ? 4'h3 : 4'h1;
    lat = 0;
    do begin
      @(posedge mclk_i);
      lat++;
    end while (avs_waitrequest_o !== 1'b0 && lat < 400);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // edges from request to completion: lead, setup, strobe, hold, tail, answer
  function automatic int exp_lat(input logic [7:0] t, input int l, input logic mux);
    return 7 + t[7:6] + t[5:2] + t[1:0] + (mux ? 2 * (l + 1) : 0);
  endfunction

  initial begin
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    bus(1'b0, `EMT_OFF_TIMING, 32'h0);
    chk("timing reset", rd, 32'hff);
    bus(1'b0, `EMT_OFF_CONFIG, 32'h0);
    chk("config reset", rd, 32'h03);
    bus(1'b0, 5'h1c, 32'h0);
    chk("unmapped read", rd, 32'h0);
    bus(1'b1, `EMT_OFF_DATA_POINTER, 32'h2345);
    // reset config is internal-only: a high address aliases on-chip, no strobe
    cnt0 = m_cnt;
    bus(1'b1, `EMT_OFF_ACCESS, 32'h3a5);
    chk("internal alias latency", lat, 32'd3);
    chk("internal no strobe", m_cnt, cnt0);
    foreach (codes[i]) begin
      bus(1'b1, `EMT_OFF_CONFIG, {27'h0, codes[i], 2'h0});
      bus(1'b1, `EMT_OFF_TIMING, 32'h0);
      bus(1'b1, `EMT_OFF_ACCESS, 32'h3a5);
      chk("mode latency", lat, exp_lat(8'h00, 0, !codes[i][2]));
      chk("mode addr", m_addr, 16'h2345);
    end
    // non-muxed bank split, timing fields swept
    bus(1'b1, `EMT_OFF_CONFIG, 32'h18);
    foreach (tms[i]) begin
      bus(1'b1, `EMT_OFF_TIMING, {24'h0, tms[i]});
      bus(1'b1, `EMT_OFF_ACCESS, 32'h3a5);
      chk("access latency", lat, exp_lat(tms[i], 0, 1'b0));
      chk("strobe width", m_width, tms[i][5:2] + 1);
    end
    bus(1'b1, `EMT_OFF_ACCESS, 32'h100);
    bus(1'b0, `EMT_OFF_STATUS, 32'h0);
    chk("offchip read", rd, 32'h1a5);
    // muxed with the widest latch pulse
    bus(1'b1, `EMT_OFF_CONFIG, 32'h0b);
    bus(1'b1, `EMT_OFF_TIMING, 32'h0);
    bus(1'b1, `EMT_OFF_ACCESS, 32'h35a);
    chk("latch latency", lat, exp_lat(8'h00, 3, 1'b1));
    bus(1'b1, `EMT_OFF_ACCESS, 32'h100);
    bus(1'b0, `EMT_OFF_STATUS, 32'h0);
    chk("mux read", rd, 32'h15a);
    // byte pointer accesses
    bus(1'b1, `EMT_OFF_CONFIG, 32'h18);
    bus(1'b1, `EMT_OFF_PAGE, 32'h37);
    bus(1'b1, `EMT_OFF_BPTR, 32'h12);
    bus(1'b1, `EMT_OFF_ACCESS, 32'h23c);
    chk("bank byte addr", {m_hi, m_addr}, 17'h13712);
    bus(1'b1, `EMT_OFF_CONFIG, 32'h1c);
    bus(1'b1, `EMT_OFF_ACCESS, 32'h23c);
    chk("ext byte hi", m_hi, 1'b0);
    chk("ext byte lo", m_addr[7:0], 8'h12);
    // low address: off-chip in external-only, on-chip in bank split
    bus(1'b1, `EMT_OFF_DATA_POINTER, 32'h0100);
    bus(1'b1, `EMT_OFF_ACCESS, 32'h366);
    chk("ext low addr", {m_hi, m_addr}, 17'h10100);
    bus(1'b1, `EMT_OFF_CONFIG, 32'h18);
    cnt0 = m_cnt;
    bus(1'b1, `EMT_OFF_ACCESS, 32'h377);
    chk("onchip latency", lat, 32'd3);
    chk("onchip no strobe", m_cnt, cnt0);
    bus(1'b1, `EMT_OFF_ACCESS, 32'h100);
    bus(1'b0, `EMT_OFF_STATUS, 32'h0);
    chk("onchip read", rd, 32'h077);
    bus(1'b1, `EMT_OFF_CONFIG, 32'h1c);
    bus(1'b1, `EMT_OFF_ACCESS, 32'h100);
    bus(1'b0, `EMT_OFF_STATUS, 32'h0);
    chk("ram hidden", rd, 32'h166);
    print_verdict();
  end
endmodule
